// >>> hdl/amc_pkg.sv
// Constants, types and register map of the amplifier mode and host configuration block
//
// Overview of operation
// - Switching ratios 38, 44, 48 times sample rate
// - Lower switching ratios 8 and 10 also offered
// - Bridged pair with unequal states reports fault
// - Paralleled bridge request applies only in standby
// - Load diagnostic runs on paralleled bridge channels
// - Per-channel line driver select in channel_mode_control
// - Control bus target only, never drives clock
// - I2S, left, right justified and TDM framing
// - Sample rates 96, 48 and 44.1 kHz
// - Port bits 3 to 5 matter only in TDM
// - Writing misc bit 7 clears latched faults
// - Misc bit 6 routes input channels to outputs
`default_nettype none

package amc_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] REG_CHMODE = 8'h00;
   localparam logic [7:0] REG_PWM = 8'h01;
   localparam logic [7:0] REG_SAP = 8'h03;
   localparam logic [7:0] REG_STATE = 8'h04;
   localparam logic [7:0] REG_DIAG = 8'h05;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_MISC3 = 8'h21;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] RST_CHMODE = 8'h00;
   localparam logic [2:0] RST_PWM = 3'h3;
   localparam logic [7:0] RST_SAP = 8'h04;
   localparam logic [3:0] RST_STATE = 4'h0;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CHM_LINE1 = 0;
   localparam int CHM_LINE2 = 1;
   localparam int CHM_PARALLELED_BRIDGE_MODE = 2;
   localparam int SAP_SLOT_LSB = 3;
   localparam int SAP_RATE_LSB = 6;
   localparam int DIAG_START = 0;
   localparam int DIAG_CH_LSB = 1;
   localparam int STS_MISMATCH = 0;
   localparam int STS_PARALLELED_BRIDGE_MODE = 1;
   localparam int STS_DIAG_DONE = 2;
   localparam int STS_OVERRUN = 3;
   localparam int STS_DIAG_BUSY = 4;
   localparam int MISC3_SWAP = 6;
   localparam int MISC3_CLEAR = 7;

   // ***************************************************************
   // Encodings
   // ***************************************************************
   typedef enum logic [2:0] {
      FMT_RJ16 = 3'h0, FMT_RJ18 = 3'h1, FMT_RJ20 = 3'h2, FMT_RJ24 = 3'h3,
      FMT_I2S = 3'h4, FMT_LJ = 3'h5, FMT_TDM = 3'h6, FMT_RSVD = 3'h7
   } amc_fmt_t;
   localparam logic [1:0] RATE_44K1 = 2'h0;
   localparam logic [1:0] RATE_48K = 2'h1;
   localparam logic [1:0] RATE_96K = 2'h2;
   localparam logic [1:0] CHST_STANDBY = 2'h0;
   localparam logic [2:0] SW_MAX_CODE = 3'h4;
   localparam logic [5:0] RATIO_8 = 6'h08;
   localparam logic [5:0] RATIO_10 = 6'h0a;
   localparam logic [5:0] RATIO_38 = 6'h26;
   localparam logic [5:0] RATIO_44 = 6'h2c;
   localparam logic [5:0] RATIO_48 = 6'h30;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int SYS_CLK_KHZ = 20000;
   localparam int DIAG_TIME_US = 100;
   localparam logic [15:0] DIAG_CYCLES = 16'((DIAG_TIME_US * SYS_CLK_KHZ) / 1000);

endpackage

`default_nettype wire

// >>> hdl/amc_top.sv
// Mode control, control bus target, audio port capture and sample FIFO
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// Sample FIFO
// ***************************************************************
module amc_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } amc_fifo_t;
   amc_fifo_t f_q, f_d;
   logic push, pop;

   assign in_ready = (f_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (f_q.cnt != '0);
   assign out_data = f_q.mem[f_q.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      f_d = f_q;
      if (push) begin
         f_d.mem[f_q.wp] = in_data;
         f_d.wp = (f_q.wp == AW'(DEPTH-1)) ? '0 : f_q.wp + 1'b1;
      end
      if (pop) begin
         f_d.rp = (f_q.rp == AW'(DEPTH-1)) ? '0 : f_q.rp + 1'b1;
      end
      f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (!rst_n) begin
         f_d.wp = '0;
         f_d.rp = '0;
         f_d.cnt = '0;
      end
   end

   always_ff @(posedge clk) begin
      f_q <= f_d;
   end

   no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
      f_q.cnt == (AW+1)'(DEPTH) |=> f_q.cnt <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
   fifo_full_c: cover property (@(posedge clk) disable iff (!rst_n) !in_ready);
endmodule // amc_fifo

// ***************************************************************
// Top
// ***************************************************************
module amc_top
   import amc_pkg::*;
#(
   parameter logic [6:0] ADDR_BASE = 7'h2c, // Arbitrary value
   parameter logic [15:0] DIAG_LEN = DIAG_CYCLES,
   parameter int FIFO_DEPTH = 8
) (
   // System
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Control bus pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   input wire logic [1:0] ADDR_SEL,
   // Audio link
   input wire logic BIT_CLK,
   input wire logic FRAME_CLK,
   input wire logic SERIAL_DATA,
   // Sample stream
   output logic [31:0] SAMPLE_DATA,
   output logic SAMPLE_CHAN,
   output logic SAMPLE_VALID,
   input wire logic SAMPLE_READY,
   // Mode outputs
   output logic [1:0] LINE_DRIVER,
   output logic PARALLELED_BRIDGE_MODE_ACTIVE,
   output logic [5:0] SW_RATIO,
   output logic [1:0] SAMPLE_RATE,
   output logic [3:0] CHANNEL_STATE,
   output logic FAULT,
   output logic [1:0] DIAG_RUN
);
   typedef enum logic [3:0] {
      BS_IDLE = 4'h0, BS_ADDR = 4'h1, BS_ADDR_ACK = 4'h2, BS_REG = 4'h3, BS_REG_ACK = 4'h4,
      BS_WR = 4'h5, BS_WR_ACK = 4'h6, BS_RD = 4'h7, BS_RD_ACK = 4'h8
   } amc_bus_t;

   typedef struct packed {
      amc_bus_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rw;
      logic ack;
      logic oe_n;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [1:0] addr_s1;
      logic [1:0] addr_s2;
      logic [1:0] addr_lo;
      logic [7:0] chmode;
      logic [2:0] pwm;
      logic [5:0] sw_ratio;
      logic [7:0] serial_audio_port;
      logic [3:0] chst;
      logic swap;
      logic paralleled_bridge_mode;
      logic mismatch;
      logic overrun;
      logic diag_done;
      logic [1:0] diag_ch;
      logic [15:0] diag_cnt;
      logic [2:0] tog_s;
      logic [3:0] settle;
      logic [31:0] out_data;
      logic out_chan;
      logic out_valid;
   } amc_sys_t;

   typedef struct packed {
      logic [5:0] cfg1;
      logic [5:0] cfg2;
      logic fr_q;
      logic [7:0] cnt;
      logic [31:0] shift;
      logic [31:0] word;
      logic chan;
      logic tog;
   } amc_link_t;

   amc_sys_t s_q, s_d;
   amc_link_t l_q, l_d;
   logic [1:0] lrst_q;
   logic scl_r, scl_f, start, stop, wr_en, both_stby, clr;
   logic push_valid, rchan, f_in_ready, f_out_valid, f_out_ready;
   logic [32:0] f_out_data;
   logic [7:0] rd_byte;
   logic [2:0] fmt;
   logic [31:0] sample;
   logic emit;
   logic [7:0] cnt_n;
   logic [2:0] slot_n;

   function automatic logic [7:0] rd_mux(input amc_sys_t s, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         REG_CHMODE: v = s.chmode;
         REG_PWM: v = {5'h00, s.pwm};
         REG_SAP: v = s.serial_audio_port;
         REG_STATE: v = {4'h0, s.chst};
         REG_DIAG: v = {5'h00, s.diag_ch, 1'b0};
         REG_STATUS: v = {3'h0, |s.diag_ch, s.overrun, s.diag_done, s.paralleled_bridge_mode, s.mismatch};
         REG_MISC3: v = {1'b0, s.swap, 6'h00};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ***************************************************************
   // Control bus target and registers
   // ***************************************************************
   assign scl_r = s_q.scl_s[1] & ~s_q.scl_s[2];
   assign scl_f = ~s_q.scl_s[1] & s_q.scl_s[2];
   assign start = s_q.scl_s[1] & s_q.scl_s[2] & ~s_q.sda_s[1] & s_q.sda_s[2];
   assign stop = s_q.scl_s[1] & s_q.scl_s[2] & s_q.sda_s[1] & ~s_q.sda_s[2];
   assign both_stby = (s_q.chst[1:0] == CHST_STANDBY) && (s_q.chst[3:2] == CHST_STANDBY);
   assign rd_byte = rd_mux(s_q, s_q.ptr);
   assign wr_en = (s_q.st == BS_WR) && scl_f && (s_q.bitcnt == 4'h8);
   assign clr = wr_en && (s_q.ptr == REG_MISC3) && s_q.shreg[MISC3_CLEAR];
   assign rchan = l_q.chan ^ s_q.swap;
   assign push_valid = (s_q.tog_s[1] ^ s_q.tog_s[2]) && (s_q.settle == 4'hf) &&
      !(s_q.paralleled_bridge_mode && rchan);
   assign f_out_ready = ~s_q.out_valid | SAMPLE_READY;

   always_comb begin
      s_d = s_q;
      s_d.scl_s = {s_q.scl_s[1:0], SCL_IN};
      s_d.sda_s = {s_q.sda_s[1:0], SDA_IN};
      s_d.addr_s1 = ADDR_SEL;
      s_d.addr_s2 = s_q.addr_s1;
      s_d.tog_s = {s_q.tog_s[1:0], l_q.tog};
      // Ignore the link until its own reset has reached the toggle synchroniser
      if (s_q.settle != 4'hf) begin
         s_d.settle = s_q.settle + 4'h1;
      end
      // Target only: SCL is never an output, SDA only acknowledges or returns data
      case (s_q.st)
         BS_IDLE: begin
         end
         BS_ADDR, BS_REG, BS_WR: begin
            if (scl_r) begin
               s_d.shreg = {s_q.shreg[6:0], s_q.sda_s[1]};
               s_d.bitcnt = s_q.bitcnt + 4'h1;
            end
            if (scl_f && s_q.bitcnt == 4'h8) begin
               s_d.oe_n = 1'b0;
               s_d.bitcnt = 4'h0;
               if (s_q.st == BS_ADDR) begin
                  s_d.rw = s_q.shreg[0];
                  s_d.st = BS_ADDR_ACK;
                  if (s_q.shreg[7:1] != {ADDR_BASE[6:2], s_q.addr_lo}) begin
                     s_d.oe_n = 1'b1;
                     s_d.st = BS_IDLE;
                  end
               end else if (s_q.st == BS_REG) begin
                  s_d.ptr = s_q.shreg;
                  s_d.st = BS_REG_ACK;
               end else begin
                  s_d.st = BS_WR_ACK;
               end
            end
         end
         BS_ADDR_ACK, BS_RD_ACK: begin
            if (scl_r) begin
               s_d.ack = ~s_q.sda_s[1];
            end
            if (scl_f) begin
               s_d.bitcnt = 4'h0;
               s_d.oe_n = 1'b1;
               if (s_q.rw && (s_q.st == BS_ADDR_ACK || s_q.ack)) begin
                  s_d.oe_n = rd_byte[7];
                  s_d.shreg = {rd_byte[6:0], 1'b0};
                  s_d.ptr = s_q.ptr + 8'h01;
                  s_d.st = BS_RD;
               end else if (s_q.st == BS_ADDR_ACK) begin
                  s_d.st = BS_REG;
               end else begin
                  s_d.st = BS_IDLE;
               end
            end
         end
         BS_REG_ACK, BS_WR_ACK: begin
            if (scl_f) begin
               s_d.oe_n = 1'b1;
               s_d.st = BS_WR;
               if (s_q.st == BS_WR_ACK) begin
                  s_d.ptr = s_q.ptr + 8'h01;
               end
            end
         end
         BS_RD: begin
            if (scl_r) begin
               s_d.bitcnt = s_q.bitcnt + 4'h1;
            end
            if (scl_f) begin
               if (s_q.bitcnt == 4'h8) begin
                  s_d.oe_n = 1'b1;
                  s_d.st = BS_RD_ACK;
               end else begin
                  s_d.oe_n = s_q.shreg[7];
                  s_d.shreg = {s_q.shreg[6:0], 1'b0};
               end
            end
         end
         default: begin
            s_d.st = BS_IDLE;
            s_d.oe_n = 1'b1;
         end
      endcase
      if (start) begin
         s_d.st = BS_ADDR;
         s_d.bitcnt = 4'h0;
         s_d.oe_n = 1'b1;
      end else if (stop) begin
         s_d.st = BS_IDLE;
         s_d.oe_n = 1'b1;
      end

      // Register writes
      if (wr_en) begin
         case (s_q.ptr)
            REG_CHMODE: s_d.chmode = s_q.shreg;
            REG_PWM: if (s_q.shreg[2:0] <= SW_MAX_CODE) s_d.pwm = s_q.shreg[2:0];
            REG_SAP: begin
               s_d.serial_audio_port[5:0] = s_q.shreg[5:0];
               if (s_q.shreg[7:6] != 2'h3) s_d.serial_audio_port[7:6] = s_q.shreg[7:6];
            end
            REG_STATE: s_d.chst = s_q.shreg[3:0];
            REG_DIAG: begin
               if (s_q.shreg[DIAG_START] && s_q.diag_ch == 2'h0) begin
                  s_d.diag_ch = s_q.paralleled_bridge_mode ? 2'h3 : s_q.shreg[DIAG_CH_LSB +: 2];
                  s_d.diag_cnt = DIAG_LEN;
                  s_d.diag_done = 1'b0;
               end
            end
            REG_MISC3: s_d.swap = s_q.shreg[MISC3_SWAP];
            default: begin
            end
         endcase
      end

      // Switching ratio decode
      case (s_q.pwm)
         3'h0: s_d.sw_ratio = RATIO_8;
         3'h1: s_d.sw_ratio = RATIO_10;
         3'h2: s_d.sw_ratio = RATIO_38;
         3'h3: s_d.sw_ratio = RATIO_44;
         default: s_d.sw_ratio = RATIO_48;
      endcase

      // Bridged pairing applies only from standby
      if (both_stby) s_d.paralleled_bridge_mode = s_q.chmode[CHM_PARALLELED_BRIDGE_MODE];
      if (clr) begin
         s_d.mismatch = 1'b0;
         s_d.overrun = 1'b0;
      end
      if (s_q.paralleled_bridge_mode && s_q.chst[1:0] != s_q.chst[3:2]) s_d.mismatch = 1'b1;

      // Load diagnostic timer
      if (s_q.diag_ch != 2'h0) begin
         s_d.diag_cnt = s_q.diag_cnt - 16'h0001;
         if (s_q.diag_cnt <= 16'h0001) begin
            s_d.diag_ch = 2'h0;
            s_d.diag_done = 1'b1;
         end
      end

      // Sample routing into the FIFO and out to the stream port
      if (push_valid && !f_in_ready) s_d.overrun = 1'b1;
      if (f_out_ready) begin
         s_d.out_valid = f_out_valid;
         if (f_out_valid) {s_d.out_chan, s_d.out_data} = f_out_data;
      end

      if (!RESET_N) begin
         s_d = '0;
         s_d.st = BS_IDLE;
         s_d.oe_n = 1'b1;
         s_d.scl_s = 3'h7;
         s_d.sda_s = 3'h7;
         s_d.addr_s1 = ADDR_SEL;
         s_d.addr_s2 = s_q.addr_s1;
         s_d.addr_lo = s_q.addr_s2;
         s_d.chmode = RST_CHMODE;
         s_d.pwm = RST_PWM;
         s_d.sw_ratio = RATIO_44;
         s_d.serial_audio_port = RST_SAP;
         s_d.chst = RST_STATE;
         s_d.tog_s = {s_q.tog_s[1:0], l_q.tog};
      end
   end

   always_ff @(posedge SYS_CLK) begin
      s_q <= s_d;
   end

   amc_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .in_valid(push_valid),
      .in_ready(f_in_ready),
      .in_data({rchan, l_q.word}),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // ***************************************************************
   // Audio link capture on the bit clock
   // ***************************************************************
   always_ff @(posedge BIT_CLK) begin
      lrst_q <= {lrst_q[0], RESET_N};
   end

   assign fmt = l_q.cfg2[2:0];
   assign cnt_n = l_q.cnt + 8'h01;
   assign slot_n = cnt_n[7:5] - 3'h1;

   always_comb begin
      l_d = l_q;
      l_d.cfg1 = s_q.serial_audio_port[5:0];
      l_d.cfg2 = l_q.cfg1;
      l_d.fr_q = FRAME_CLK;
      l_d.shift = {l_q.shift[30:0], SERIAL_DATA};
      l_d.cnt = (FRAME_CLK && !l_q.fr_q) ? 8'h00 : cnt_n;
      emit = 1'b0;
      sample = {l_q.shift[30:0], SERIAL_DATA};
      case (fmt)
         FMT_RJ16: sample = {l_q.shift[15:0], 16'h0000};
         FMT_RJ18: sample = {l_q.shift[17:0], 14'h0000};
         FMT_RJ20: sample = {l_q.shift[19:0], 12'h000};
         FMT_RJ24: sample = {l_q.shift[23:0], 8'h00};
         FMT_LJ: sample = l_q.shift;
         default: sample = {l_q.shift[30:0], SERIAL_DATA};
      endcase
      if (fmt == FMT_TDM) begin
         // Slot select bits only steer capture in TDM
         if (cnt_n[4:0] == 5'h00 && !(FRAME_CLK && !l_q.fr_q)) begin
            if (slot_n == l_q.cfg2[5:3]) begin
               emit = 1'b1;
               l_d.chan = 1'b0;
            end else if (slot_n == l_q.cfg2[5:3] + 3'h1) begin
               emit = 1'b1;
               l_d.chan = 1'b1;
            end
         end
      end else if (FRAME_CLK != l_q.fr_q) begin
         emit = 1'b1;
         l_d.chan = l_q.fr_q;
      end
      if (emit) begin
         l_d.word = sample;
         l_d.tog = ~l_q.tog;
      end
      if (!lrst_q[1]) begin
         l_d = '0;
      end
   end

   always_ff @(posedge BIT_CLK) begin
      l_q <= l_d;
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign SDA_OUT = 1'b0;
   assign SDA_OE_N = s_q.oe_n;
   assign SAMPLE_DATA = s_q.out_data;
   assign SAMPLE_CHAN = s_q.out_chan;
   assign SAMPLE_VALID = s_q.out_valid;
   assign LINE_DRIVER = {s_q.chmode[CHM_LINE2], s_q.chmode[CHM_LINE1]};
   assign PARALLELED_BRIDGE_MODE_ACTIVE = s_q.paralleled_bridge_mode;
   assign SW_RATIO = s_q.sw_ratio;
   assign SAMPLE_RATE = s_q.serial_audio_port[SAP_RATE_LSB +: 2];
   assign CHANNEL_STATE = s_q.chst;
   assign FAULT = s_q.mismatch;
   assign DIAG_RUN = s_q.diag_ch;

   // ***************************************************************
   // Checks
   // ***************************************************************
   paralleled_bridge_mode_standby_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      $changed(PARALLELED_BRIDGE_MODE_ACTIVE) |-> $past(both_stby))
      else $error("pairing changed outside standby");
   pair_fault_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      PARALLELED_BRIDGE_MODE_ACTIVE && CHANNEL_STATE[1:0] != CHANNEL_STATE[3:2] |=> FAULT)
      else $error("state mismatch not flagged");
   fault_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      clr && !(s_q.paralleled_bridge_mode && s_q.chst[1:0] != s_q.chst[3:2]) |=> !FAULT)
      else $error("fault not cleared");
   idle_release_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      s_q.st == BS_IDLE |-> SDA_OE_N)
      else $error("data line driven while idle");
   ratio_high_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      s_q.pwm == 3'h3 |=> SW_RATIO == RATIO_44)
      else $error("wrong high ratio");
   ratio_low_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      s_q.pwm == 3'h0 |=> SW_RATIO == RATIO_8)
      else $error("wrong low ratio");
   line_mode_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      wr_en && s_q.ptr == REG_CHMODE |=> LINE_DRIVER == $past(s_q.shreg[1:0]))
      else $error("line driver select not applied");
   rate_legal_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      SAMPLE_RATE != 2'h3)
      else $error("illegal sample rate code");
   diag_pair_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      wr_en && s_q.ptr == REG_DIAG && s_q.shreg[0] && s_q.paralleled_bridge_mode && DIAG_RUN == 2'h0
      |=> DIAG_RUN == 2'h3 ##1 DIAG_RUN == 2'h3)
      else $error("paired diagnostic not started");
   frame_edge_a: assert property (@(posedge BIT_CLK) disable iff (!lrst_q[1])
      emit && fmt != FMT_TDM |-> FRAME_CLK != l_q.fr_q)
      else $error("capture off a frame edge");
   paralleled_bridge_mode_route_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      push_valid && s_q.paralleled_bridge_mode |-> !rchan)
      else $error("second channel queued while paired");
   paralleled_bridge_mode_enter_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) $rose(PARALLELED_BRIDGE_MODE_ACTIVE));
   read_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) s_q.st == BS_RD_ACK);
   diag_done_c: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) $rose(s_q.diag_done));
   tdm_c: cover property (@(posedge BIT_CLK) disable iff (!lrst_q[1]) emit && fmt == FMT_TDM);
endmodule // amc_top

`default_nettype wire

// >>> tb/amc_host.sv
// Control bus master model that configures the amplifier registers
`timescale 1ns/1ps
`default_nettype none
module amc_host #(
   parameter logic [6:0] ADDR = 7'h2d,
   parameter int QTR = 15
) (
   // Clock and bus lines
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv,
   // Transfer results
   output logic [7:0] rd_data,
   output logic ack_ok
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      rd_data = 8'h00;
      ack_ok = 1'b1;
   end
   task automatic q(input int n);
      repeat (n * QTR) @(negedge clk);
   endtask
   task automatic put_bit(input logic b, output logic s);
      sda_drv = b;
      q(1);
      scl = 1'b1;
      q(1);
      s = sda_line;
      q(1);
      scl = 1'b0;
      q(1);
   endtask
   task automatic put_byte(input logic [7:0] b, input logic rd, output logic [7:0] got);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], got[i]);
      end
      // Line released: the target acknowledges, or this is the closing no-acknowledge
      put_bit(1'b1, s);
      if (!rd) ack_ok = ack_ok & ~s;
   endtask
   task automatic start_c();
      sda_drv = 1'b1;
      scl = 1'b1;
      q(1);
      sda_drv = 1'b0;
      q(1);
      scl = 1'b0;
      q(1);
   endtask
   task automatic stop_c();
      sda_drv = 1'b0;
      q(1);
      scl = 1'b1;
      q(1);
      sda_drv = 1'b1;
      q(2);
   endtask
   task automatic write_reg(input logic [7:0] r, input logic [7:0] d);
      logic [7:0] g;
      ack_ok = 1'b1;
      start_c();
      put_byte({ADDR, 1'b0}, 1'b0, g);
      put_byte(r, 1'b0, g);
      put_byte(d, 1'b0, g);
      stop_c();
   endtask
   task automatic read_reg(input logic [7:0] r);
      logic [7:0] g;
      ack_ok = 1'b1;
      start_c();
      put_byte({ADDR, 1'b0}, 1'b0, g);
      put_byte(r, 1'b0, g);
      start_c();
      put_byte({ADDR, 1'b1}, 1'b0, g);
      put_byte(8'hff, 1'b1, rd_data);
      stop_c();
   endtask
endmodule // amc_host
`default_nettype wire

// >>> tb/test_amp_mode_and_host_config.sv
// Self-checking bench for the mode control and host configuration block
`timescale 1ns/1ps
`default_nettype none
module test_amp_mode_and_host_config;
   import amc_pkg::*;
   localparam logic [6:0] BASE = 7'h2c; // Arbitrary value
   localparam logic [6:0] ADDR = {BASE[6:2], 2'b01};
   localparam logic [5:0] RAT [6] = '{RATIO_8, RATIO_10, RATIO_38, RATIO_44, RATIO_48, RATIO_48};
   logic sys_clk, reset_n, bit_clk, frame_clk, serial_data, sample_ready, sample_valid;
   logic scl, sda_drv, sda_oe_n, sample_chan, paralleled_bridge_mode_active, fault;
   logic [31:0] sample_data;
   logic [1:0] line_driver, sample_rate, diag_run;
   logic [5:0] sw_ratio;
   logic [32:0] exp_q[$];
   logic [32:0] nxt;
   integer seed = 32'h4e6d52c7;
   int err_total = 0;
   int checked = 0;
   amc_host #(.ADDR(ADDR)) h (.clk(sys_clk), .sda_line(sda_drv & sda_oe_n), .scl(scl),
      .sda_drv(sda_drv), .rd_data(), .ack_ok());
   amc_top #(.ADDR_BASE(BASE), .DIAG_LEN(16'd200), .FIFO_DEPTH(8)) uut (.SYS_CLK(sys_clk),
      .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda_drv & sda_oe_n), .SDA_OUT(),
      .SDA_OE_N(sda_oe_n), .ADDR_SEL(2'b01), .BIT_CLK(bit_clk), .FRAME_CLK(frame_clk),
      .SERIAL_DATA(serial_data), .SAMPLE_DATA(sample_data), .SAMPLE_CHAN(sample_chan),
      .SAMPLE_VALID(sample_valid), .SAMPLE_READY(sample_ready), .LINE_DRIVER(line_driver),
      .PARALLELED_BRIDGE_MODE_ACTIVE(paralleled_bridge_mode_active), .SW_RATIO(sw_ratio), .SAMPLE_RATE(sample_rate),
      .CHANNEL_STATE(), .FAULT(fault), .DIAG_RUN(diag_run));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      bit_clk = 1'b0;
      #17;
      forever #62.5 bit_clk = ~bit_clk;
   end
   always @(negedge sys_clk) sample_ready <= 1'($random(seed));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      h.write_reg(r, d);
      check("ack", h.ack_ok, 1);
   endtask
   // I2S words; the frame clock leads each word's first bit by one bit clock
   task automatic send_words(input int n, input logic sw);
      logic [31:0] w;
      for (int f = 0; f < n; f++) begin
         w = $random(seed);
         exp_q.push_back({f[0] ^ sw, w});
         for (int i = 0; i < 32; i++) begin
            @(negedge bit_clk);
            serial_data = w[31-i];
            frame_clk = (i == 31) ? ~f[0] : f[0];
         end
      end
      @(negedge bit_clk);
      serial_data = ~serial_data;
   endtask
   always @(posedge sys_clk) begin
      if (reset_n && sample_valid === 1'b1 && sample_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("extra sample", 1, 0);
         end else begin
            nxt = exp_q.pop_front();
            check("sample chan", sample_chan, nxt[32]);
            check("sample data", sample_data, nxt[31:0]);
         end
      end
   end
   initial begin
      reset_n = 1'b0;
      frame_clk = 1'b0;
      serial_data = 1'b0;
      repeat (6) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("ratio rst", sw_ratio, RATIO_44);
      check("rate rst", sample_rate, RATE_44K1);
      h.read_reg(REG_SAP);
      check("sap rst", h.rd_data, 8'h04);
      h.read_reg(8'h7f);
      check("unmapped", h.rd_data, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(REG_PWM, 8'(i));
         check("sw ratio", sw_ratio, RAT[i]);
      end
      wr(REG_SAP, 8'hbc);
      check("rate 96k", sample_rate, RATE_96K);
      send_words(4, 1'b0);
      wr(REG_MISC3, 8'h40);
      send_words(4, 1'b1);
      wr(REG_SAP, 8'h44);
      check("rate 48k", sample_rate, RATE_48K);
      for (int k = 0; k < 2000 && exp_q.size() != 0; k++) @(negedge sys_clk);
      check("drain", exp_q.size(), 0);
      wr(REG_CHMODE, 8'h03);
      check("line drv", line_driver, 2'h3);
      wr(REG_STATE, 8'h05);
      wr(REG_CHMODE, 8'h04);
      check("pair busy", paralleled_bridge_mode_active, 1'b0);
      wr(REG_STATE, 8'h00);
      check("pair stby", paralleled_bridge_mode_active, 1'b1);
      wr(REG_STATE, 8'h01);
      check("mismatch", fault, 1'b1);
      wr(REG_STATE, 8'h05);
      wr(REG_MISC3, 8'h80);
      check("clear", fault, 1'b0);
      h.read_reg(REG_STATUS);
      check("no fault", h.rd_data[STS_MISMATCH], 1'b0);
      wr(REG_DIAG, 8'h03);
      check("diag run", diag_run, 2'h3);
      repeat (220) @(negedge sys_clk);
      h.read_reg(REG_DIAG);
      check("diag end", h.rd_data[2:1], 2'h0);
      print_verdict();
   end
endmodule // test_amp_mode_and_host_config
`default_nettype wire
